// *** common/bridge_regs_pkg.sv ***
package bridge_regs_pkg;

    // Register indices as printed; each register takes one word at four times its index.
    localparam logic [7:0] LAT_IDX    = 8'h1b;
    localparam logic [7:0] BASE_IDX   = 8'h1c;
    localparam logic [7:0] LIMIT_IDX  = 8'h1d;
    localparam logic [7:0] STATUS_IDX = 8'h1e;
    localparam logic [7:0] MASK_IDX   = 8'h20;

    // Byte addresses on the register bus.
    localparam logic [9:0] LAT_ADDR    = {LAT_IDX, 2'h0};
    localparam logic [9:0] BASE_ADDR   = {BASE_IDX, 2'h0};
    localparam logic [9:0] LIMIT_ADDR  = {LIMIT_IDX, 2'h0};
    localparam logic [9:0] STATUS_ADDR = {STATUS_IDX, 2'h0};
    localparam logic [9:0] MASK_ADDR   = {MASK_IDX, 2'h0};

    // Reset values.
    localparam logic [7:0]  LAT_RESET    = 8'h00;
    localparam logic [7:0]  BASE_RESET   = 8'hf0;
    localparam logic [7:0]  LIMIT_RESET  = 8'h00;
    localparam logic [15:0] STATUS_RESET = 16'h02a0;
    localparam logic [15:0] MASK_RESET   = 16'h0000;

    // Field positions.
    localparam int LAT_MSB     = 7;
    localparam int LAT_LSB     = 3;
    localparam int WIN_MSB     = 7;
    localparam int WIN_LSB     = 4;
    localparam int PERR_BIT    = 15;
    localparam int SERR_BIT    = 14;
    localparam int MABORT_BIT  = 13;
    localparam int TABORT_BIT  = 12;
    localparam int TSIG_BIT    = 11;
    localparam int TIMING_LSB  = 9;
    localparam int MPERR_BIT   = 8;
    localparam int B2B_BIT     = 7;
    localparam int SPEED_BIT   = 5;

    // Fixed status codes and the writable-one-to-clear bits.
    localparam logic [1:0]  TIMING_CODE   = 2'h1;
    localparam logic [15:0] STATUS_W1C    = 16'hb000;

    // The window decodes address bits 15:12; the low twelve bits are implied.
    localparam logic [11:0] WIN_LOW_FILL  = 12'h000;
    localparam logic [11:0] WIN_HIGH_FILL = 12'hfff;

    // Each unit of the latency value stands for this many clocks, as a left shift.
    localparam int TENURE_SHIFT = 3;

    // Bus transfer type bit that marks an active transfer.
    localparam int HTRANS_ACTIVE_BIT = 1;

endpackage : bridge_regs_pkg

// *** sim/bridge_io_window_secondary_status_tb.sv ***
`timescale 1ns/1ps

module bridge_io_window_secondary_status_tb;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        hreadyout, hresp, tenure_stop, io_forward_valid, io_forward, irq;
    logic [31:0] hrdata;
    logic        perr, mabort, tabort, frame, grant;
    logic        io_req_valid = 1'b0;
    logic [15:0] io_req_addr = 16'h0;
    int          n_mismatch = 0;
    int          checks = 0;

    // The clock toggles every half period of 4 ns.
    always #4 hclk = ~hclk;

    bridge_io_window_secondary_status bridge_io_window_secondary_status_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .sec_parity_error(perr), .sec_master_abort(mabort), .sec_target_abort(tabort),
        .master_frame(frame), .grant_held(grant), .tenure_stop(tenure_stop),
        .io_req_valid(io_req_valid), .io_req_addr(io_req_addr),
        .io_forward_valid(io_forward_valid), .io_forward(io_forward), .irq(irq));

    sec_bus_agent sec_bus_agent_i (
        .clk(hclk), .sec_parity_error(perr), .sec_master_abort(mabort),
        .sec_target_abort(tabort), .master_frame(frame), .grant_held(grant));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    task automatic results;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    // One single transfer; the wait ends only on hready, never on a cycle count.
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd,
                        output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0, "response");
    endtask : xfer

    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        logic [31:0] unused;
        xfer({22'h0, a}, 1'b1, d, unused);
    endtask : wr

    task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp, input string what);
        logic [31:0] v;
        xfer({22'h0, a}, 1'b0, 32'h0, v);
        chk(v, exp, what);
    endtask : rd_chk

    // Reset values, then writes of ones (status skips its clear-on-one bits) show which bits are really writable.
    task automatic t_regs;
        rd_chk(bridge_regs_pkg::LAT_ADDR, 32'h0, "lat reset");
        rd_chk(bridge_regs_pkg::BASE_ADDR, 32'hf0, "base reset");
        rd_chk(bridge_regs_pkg::LIMIT_ADDR, 32'h0, "limit reset");
        rd_chk(bridge_regs_pkg::STATUS_ADDR, 32'h2a0, "status reset");
        rd_chk(10'h3fc, 32'h0, "unmapped");
        wr(bridge_regs_pkg::LAT_ADDR, 32'hffffffff);
        wr(bridge_regs_pkg::BASE_ADDR, 32'hffffffff);
        wr(bridge_regs_pkg::LIMIT_ADDR, 32'hffffffff);
        wr(bridge_regs_pkg::STATUS_ADDR, 32'hffff4fff);
        rd_chk(bridge_regs_pkg::LAT_ADDR, 32'hf8, "lat field");
        rd_chk(bridge_regs_pkg::BASE_ADDR, 32'hf0, "base field");
        rd_chk(bridge_regs_pkg::LIMIT_ADDR, 32'hf0, "limit field");
        rd_chk(bridge_regs_pkg::STATUS_ADDR, 32'h2a0, "fixed bits");
        $display("test regs done");
    endtask : t_regs

    // Back-to-back lookups at both edges of a window from 2000h to 3fffh.
    task automatic t_window;
        logic [15:0] a [5] = '{16'h1fff, 16'h2000, 16'h2abc, 16'h3fff, 16'h4000};
        logic        e [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
        wr(bridge_regs_pkg::BASE_ADDR, 32'h2f);
        wr(bridge_regs_pkg::LIMIT_ADDR, 32'h3a);
        for (int i = 0; i <= 5; i++) begin
            @(posedge hclk);
            io_req_valid <= (i < 5);
            io_req_addr  <= (i < 5) ? a[i % 5] : 16'h0;
            #1;
            if (i > 0) begin
                chk({31'h0, io_forward_valid}, 32'h1, "fwd valid");
                chk({31'h0, io_forward}, {31'h0, e[i - 1]}, "fwd");
            end
        end
        // The valid flag follows the requests one clock later and must drop once requests stop.
        @(posedge hclk);
        #1;
        chk({31'h0, io_forward_valid}, 32'h0, "fwd valid end");
        $display("test window done");
    endtask : t_window

    // Each fault sets its own flag; a zero write keeps it, a one write clears it.
    task automatic t_events;
        int bits [3] = '{15, 13, 12};
        rd_chk(bridge_regs_pkg::MASK_ADDR, 32'h0, "mask reset");
        sec_bus_agent_i.pulse(0);
        repeat (3) @(posedge hclk);
        chk({31'h0, irq}, 32'h0, "masked irq");
        wr(bridge_regs_pkg::MASK_ADDR, 32'hffff);
        rd_chk(bridge_regs_pkg::MASK_ADDR, 32'hb000, "mask bits");
        chk({31'h0, irq}, 32'h1, "unmasked irq");
        wr(bridge_regs_pkg::STATUS_ADDR, 32'h8000);
        for (int k = 0; k < 3; k++) begin
            sec_bus_agent_i.pulse(k);
            rd_chk(bridge_regs_pkg::STATUS_ADDR, 32'h2a0 | (32'h1 << bits[k]), "flag");
            chk({31'h0, irq}, 32'h1, "irq");
            wr(bridge_regs_pkg::STATUS_ADDR, 32'h0);
            rd_chk(bridge_regs_pkg::STATUS_ADDR, 32'h2a0 | (32'h1 << bits[k]), "keep");
            wr(bridge_regs_pkg::STATUS_ADDR, 32'h1 << bits[k]);
            rd_chk(bridge_regs_pkg::STATUS_ADDR, 32'h2a0, "clear");
            chk({31'h0, irq}, 32'h0, "irq off");
        end
        $display("test events done");
    endtask : t_events

    // A value of one allows eight clocks of tenure; zero never stops the bridge.
    task automatic t_tenure;
        wr(bridge_regs_pkg::LAT_ADDR, 32'h08);
        sec_bus_agent_i.tenure(1'b1, 1'b0);
        // Load at the first frame edge, eight counts, then stop one clock after expiry.
        repeat (9) @(posedge hclk);
        chk({31'h0, tenure_stop}, 32'h0, "early stop");
        repeat (2) @(posedge hclk);
        chk({31'h0, tenure_stop}, 32'h1, "stop");
        sec_bus_agent_i.tenure(1'b0, 1'b1);
        repeat (3) @(posedge hclk);
        chk({31'h0, tenure_stop}, 32'h0, "released");
        wr(bridge_regs_pkg::LAT_ADDR, 32'h0);
        sec_bus_agent_i.tenure(1'b1, 1'b0);
        repeat (20) @(posedge hclk);
        chk({31'h0, tenure_stop}, 32'h0, "disabled");
        sec_bus_agent_i.tenure(1'b0, 1'b1);
        $display("test tenure done");
    endtask : t_tenure

    // Reset for eight clocks, then the scenarios in turn.
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_window();
        t_events();
        t_tenure();
        results();
    end

    // The tests take a few hundred clocks; far beyond that the run has hung.
    initial begin
        #100us;
        n_mismatch++;
        results();
    end
endmodule : bridge_io_window_secondary_status_tb

// *** sim/sec_bus_agent.sv ***
`timescale 1ns/1ps

// Stands in for the secondary bus agents: fault pulses and master tenures.
module sec_bus_agent (
    input  wire logic clk,
    output logic      sec_parity_error,
    output logic      sec_master_abort,
    output logic      sec_target_abort,
    output logic      master_frame,
    output logic      grant_held
);
    // The bus starts idle with the grant still given.
    initial begin
        sec_parity_error = 1'b0;
        sec_master_abort = 1'b0;
        sec_target_abort = 1'b0;
        master_frame     = 1'b0;
        grant_held       = 1'b1;
    end

    // A fault is reported for exactly one clock, so the flag must be sticky to be seen.
    task automatic pulse(input int k);
        @(posedge clk);
        sec_parity_error <= (k == 0);
        sec_master_abort <= (k == 1);
        sec_target_abort <= (k == 2);
        @(posedge clk);
        sec_parity_error <= 1'b0;
        sec_master_abort <= 1'b0;
        sec_target_abort <= 1'b0;
    endtask : pulse

    // The arbiter may withdraw the grant while the bridge still holds the bus.
    task automatic tenure(input logic frame, input logic grant);
        @(posedge clk);
        master_frame <= frame;
        grant_held   <= grant;
    endtask : tenure
endmodule : sec_bus_agent

// *** src/bridge_io_window_secondary_status.sv ***
`timescale 1ns/1ps

// Function
// R1: Bits 7:3 of the latency register hold a five-bit tenure value, and zero disables it.
// R2: The tenure value limits how long the bridge holds the secondary bus as master.
// R3: Bits 7:4 of the I/O base register give address bits 15:12 of the window bottom.
// R4: Only the upper four bits of the I/O base and limit registers can be written.
// R5: An I/O access is forwarded when base <= address <= limit.
// R6: The bottom comparison treats address bits 11:0 as zeros.
// R7: The top comparison treats address bits 11:0 as ones.
// R8: Status bit 15 sets on a secondary bus address or data parity error.
// R9: Status bit 13 sets when a host transfer ends with an unexpected master abort.
// R10: Status bit 12 sets when a bridge transfer is ended by a target abort.
// R11: Status bits 15, 13 and 12 clear only by writing one; zero leaves them.
// R12: Status bits 14, 11 and 8 always read as zero.
// R13: Status bits 10:9 read the fixed medium select timing code 01b.
// R14: Status bit 7 reads one to show fast back-to-back target support.
// R15: Status bit 5 reads one to show the secondary bus runs at 66 MHz.
// R16: Reserved bits read zero and ignore writes.
module bridge_io_window_secondary_status (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        sec_parity_error,
    input  wire logic        sec_master_abort,
    input  wire logic        sec_target_abort,
    input  wire logic        master_frame,
    input  wire logic        grant_held,
    output logic             tenure_stop,
    input  wire logic        io_req_valid,
    input  wire logic [15:0] io_req_addr,
    output logic             io_forward_valid,
    output logic             io_forward,
    output logic             irq
);

    typedef enum logic {ST_IDLE, ST_ACCESS} bus_state_type;

    bus_state_type state_reg;
    logic [9:0]    acc_addr_reg;
    logic          acc_write_reg;
    logic          hreadyout_reg;
    logic          hresp_reg;
    logic [31:0]   hrdata_reg;
    logic [4:0]    lat_value_reg;
    logic [3:0]    io_base_reg;
    logic [3:0]    io_limit_reg;
    logic          parity_error_seen_reg;
    logic          master_abort_received_reg;
    logic          target_abort_received_reg;
    logic [15:0]   irq_mask_reg;
    logic          irq_reg;
    logic          io_forward_reg;
    logic          io_forward_valid_reg;
    logic          accept;
    logic          wr_lat;
    logic          wr_base;
    logic          wr_limit;
    logic          wr_status;
    logic          wr_mask;
    logic [15:0]   status_value;
    logic [31:0]   read_value;
    logic [15:0]   window_low;
    logic [15:0]   window_high;

    assign hreadyout        = hreadyout_reg;
    assign hresp            = hresp_reg;
    assign hrdata           = hrdata_reg;
    assign irq              = irq_reg;
    assign io_forward       = io_forward_reg;
    assign io_forward_valid = io_forward_valid_reg;

    // An address phase is taken only while the bus is ready and the slave selected.
    assign accept = hsel && htrans[bridge_regs_pkg::HTRANS_ACTIVE_BIT] && hready;

    // Every transfer takes one wait state so writes land before any following read.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg     <= ST_IDLE;
            acc_addr_reg  <= 10'h000;
            acc_write_reg <= 1'b0;
            hreadyout_reg <= 1'b1;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (accept) begin
                        state_reg     <= ST_ACCESS;
                        acc_addr_reg  <= haddr[9:0];
                        acc_write_reg <= hwrite;
                        hreadyout_reg <= 1'b0;
                    end
                end
                ST_ACCESS: begin
                    state_reg     <= ST_IDLE;
                    hreadyout_reg <= 1'b1;
                end
                default: begin
                    state_reg     <= ST_IDLE;
                    hreadyout_reg <= 1'b1;
                end
            endcase
        end
    end

    // The slave never signals an error, so unmapped words simply read zero.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp_reg <= 1'b0;
        end else begin
            hresp_reg <= 1'b0;
        end
    end

    // Write strobes fire in the wait cycle of the data phase, when hwdata stands.
    always_comb begin
        wr_lat    = 1'b0;
        wr_base   = 1'b0;
        wr_limit  = 1'b0;
        wr_status = 1'b0;
        wr_mask   = 1'b0;
        if (state_reg == ST_ACCESS && acc_write_reg) begin
            if (acc_addr_reg == bridge_regs_pkg::LAT_ADDR) begin
                wr_lat = 1'b1;
            end else if (acc_addr_reg == bridge_regs_pkg::BASE_ADDR) begin
                wr_base = 1'b1;
            end else if (acc_addr_reg == bridge_regs_pkg::LIMIT_ADDR) begin
                wr_limit = 1'b1;
            end else if (acc_addr_reg == bridge_regs_pkg::STATUS_ADDR) begin
                wr_status = 1'b1;
            end else if (acc_addr_reg == bridge_regs_pkg::MASK_ADDR) begin
                wr_mask = 1'b1;
            end
        end
    end

    // Only the tenure field is stored; bits 2:0 have no flops at all.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lat_value_reg <= bridge_regs_pkg::LAT_RESET[bridge_regs_pkg::LAT_MSB:
                                                        bridge_regs_pkg::LAT_LSB];
        end else if (wr_lat) begin
            lat_value_reg <= hwdata[bridge_regs_pkg::LAT_MSB:bridge_regs_pkg::LAT_LSB]; // see R1
        end
    end

    // Window bounds keep only their upper nibble; the low nibble is not writable.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            io_base_reg  <= bridge_regs_pkg::BASE_RESET[bridge_regs_pkg::WIN_MSB:
                                                        bridge_regs_pkg::WIN_LSB];
            io_limit_reg <= bridge_regs_pkg::LIMIT_RESET[bridge_regs_pkg::WIN_MSB:
                                                         bridge_regs_pkg::WIN_LSB];
        end else begin
            if (wr_base) begin
                io_base_reg <= hwdata[bridge_regs_pkg::WIN_MSB:bridge_regs_pkg::WIN_LSB]; // see R4
            end
            if (wr_limit) begin
                io_limit_reg <= hwdata[bridge_regs_pkg::WIN_MSB:bridge_regs_pkg::WIN_LSB]; // see R4
            end
        end
    end

    // A new error wins over a clear in the same cycle so no event is lost.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            parity_error_seen_reg     <= bridge_regs_pkg::STATUS_RESET[bridge_regs_pkg::PERR_BIT];
            master_abort_received_reg <= bridge_regs_pkg::STATUS_RESET[bridge_regs_pkg::MABORT_BIT];
            target_abort_received_reg <= bridge_regs_pkg::STATUS_RESET[bridge_regs_pkg::TABORT_BIT];
        end else begin
            if (sec_parity_error) begin
                parity_error_seen_reg <= 1'b1; // see R8
            end else if (wr_status && hwdata[bridge_regs_pkg::PERR_BIT]) begin
                parity_error_seen_reg <= 1'b0; // see R11
            end
            if (sec_master_abort) begin
                master_abort_received_reg <= 1'b1; // see R9
            end else if (wr_status && hwdata[bridge_regs_pkg::MABORT_BIT]) begin
                master_abort_received_reg <= 1'b0; // see R11
            end
            if (sec_target_abort) begin
                target_abort_received_reg <= 1'b1; // see R10
            end else if (wr_status && hwdata[bridge_regs_pkg::TABORT_BIT]) begin
                target_abort_received_reg <= 1'b0; // see R11
            end
        end
    end

    // The mask shares the status layout; only the sticky error positions exist.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask_reg <= bridge_regs_pkg::MASK_RESET;
        end else if (wr_mask) begin
            irq_mask_reg <= hwdata[15:0] & bridge_regs_pkg::STATUS_W1C; // see R16
        end
    end

    // Assemble the status word; capability bits are constants, not flops.
    always_comb begin
        status_value = 16'h0000; // see R16
        status_value[bridge_regs_pkg::PERR_BIT]   = parity_error_seen_reg;
        status_value[bridge_regs_pkg::SERR_BIT]   = 1'b0; // see R12
        status_value[bridge_regs_pkg::MABORT_BIT] = master_abort_received_reg;
        status_value[bridge_regs_pkg::TABORT_BIT] = target_abort_received_reg;
        status_value[bridge_regs_pkg::TSIG_BIT]   = 1'b0; // see R12
        status_value[bridge_regs_pkg::TIMING_LSB +: 2] = bridge_regs_pkg::TIMING_CODE; // see R13
        status_value[bridge_regs_pkg::MPERR_BIT]  = 1'b0; // see R12
        status_value[bridge_regs_pkg::B2B_BIT]    = 1'b1; // see R14
        status_value[bridge_regs_pkg::SPEED_BIT]  = 1'b1; // see R15
    end

    // Read mux; narrow registers sit at their field bits in the low byte and the rest reads zero.
    always_comb begin
        read_value = 32'h0000_0000;
        if (acc_addr_reg == bridge_regs_pkg::LAT_ADDR) begin
            read_value[bridge_regs_pkg::LAT_MSB:bridge_regs_pkg::LAT_LSB] = lat_value_reg;
        end else if (acc_addr_reg == bridge_regs_pkg::BASE_ADDR) begin
            read_value[bridge_regs_pkg::WIN_MSB:bridge_regs_pkg::WIN_LSB] = io_base_reg;
        end else if (acc_addr_reg == bridge_regs_pkg::LIMIT_ADDR) begin
            read_value[bridge_regs_pkg::WIN_MSB:bridge_regs_pkg::WIN_LSB] = io_limit_reg;
        end else if (acc_addr_reg == bridge_regs_pkg::STATUS_ADDR) begin
            read_value[15:0] = status_value;
        end else if (acc_addr_reg == bridge_regs_pkg::MASK_ADDR) begin
            read_value[15:0] = irq_mask_reg;
        end
    end

    // Read data is captured in the wait cycle and stands until the next read.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (state_reg == ST_ACCESS && !acc_write_reg) begin
            hrdata_reg <= read_value;
        end
    end

    // The interrupt is a level: high while any unmasked sticky bit is set.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(status_value & irq_mask_reg);
        end
    end

    // Window edges: bits 11:0 are implied zeros below and ones above.
    assign window_low  = {io_base_reg, bridge_regs_pkg::WIN_LOW_FILL};   // see R3, R6
    assign window_high = {io_limit_reg, bridge_regs_pkg::WIN_HIGH_FILL}; // see R7

    // A base above the limit leaves the window empty, which is how software shuts it.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            io_forward_valid_reg <= 1'b0;
            io_forward_reg       <= 1'b0;
        end else begin
            io_forward_valid_reg <= io_req_valid;
            if (io_req_valid) begin
                io_forward_reg <= (io_req_addr >= window_low)
                                  && (io_req_addr <= window_high); // see R5
            end
        end
    end

    // The tenure counter lives in its own module; its stop output is a flop.
    tenure_timer u_tenure_timer (
        .clk          (hclk),
        .rst_n        (hresetn),
        .limit_value  (lat_value_reg), // see R2
        .frame_active (master_frame),
        .grant_held   (grant_held),
        .stop         (tenure_stop)
    );

    // Checks below watch only what this block drives.
    default clocking cb @(posedge hclk);
    endclocking

    default disable iff (!hresetn);

    sequence status_read_seq;
        accept && !hwrite && haddr[9:0] == bridge_regs_pkg::STATUS_ADDR
        ##1 !hreadyout_reg ##1 hreadyout_reg;
    endsequence

    sequence base_read_seq;
        accept && !hwrite && haddr[9:0] == bridge_regs_pkg::BASE_ADDR
        ##1 !hreadyout_reg ##1 hreadyout_reg;
    endsequence

    a_bus_wait_state: assert property ( // checks the single wait state of every transfer
        accept |=> !hreadyout_reg ##1 hreadyout_reg)
        else $error("transfer did not complete after one wait state");

    a_lat_zero_idle: assert property ( // see R1
        $past(lat_value_reg) == 5'h00 |-> !tenure_stop)
        else $error("tenure stop raised with the timer disabled");

    a_stop_cause: assert property ( // see R2
        tenure_stop |-> $past(master_frame) && !$past(grant_held))
        else $error("tenure stop without a frame and a lost grant");

    a_window_decode: assert property ( // see R5
        io_req_valid |=> io_forward_valid_reg
        && io_forward_reg == ($past(io_req_addr) >= {$past(io_base_reg), 12'h000}
        && $past(io_req_addr) <= {$past(io_limit_reg), 12'hfff}))
        else $error("forward decision disagrees with the window");

    a_base_nibble_zero: assert property ( // see R4
        base_read_seq |-> hrdata_reg[3:0] == 4'h0 && hrdata_reg[31:8] == 24'h0)
        else $error("base register reserved bits read nonzero");

    a_parity_sticky: assert property ( // see R8
        sec_parity_error |=> parity_error_seen_reg [*2])
        else $error("parity event not held");

    a_mabort_sets: assert property ( // see R9
        sec_master_abort |=> master_abort_received_reg)
        else $error("master abort event not recorded");

    a_tabort_sets: assert property ( // see R10
        sec_target_abort |=> target_abort_received_reg)
        else $error("target abort event not recorded");

    a_one_clears: assert property ( // see R11
        wr_status && hwdata[bridge_regs_pkg::PERR_BIT] && !sec_parity_error
        |=> !parity_error_seen_reg)
        else $error("write of one did not clear the parity flag");

    a_zero_keeps: assert property ( // see R11
        wr_status && !hwdata[bridge_regs_pkg::MABORT_BIT] && master_abort_received_reg
        |=> master_abort_received_reg)
        else $error("write of zero cleared the master abort flag");

    a_status_fixed: assert property ( // see R12
        status_read_seq |-> hrdata_reg[14] == 1'b0 && hrdata_reg[11] == 1'b0
        && hrdata_reg[8] == 1'b0 && hrdata_reg[10:9] == 2'h1 && hrdata_reg[7]
        && hrdata_reg[5] && hrdata_reg[31:16] == 16'h0000)
        else $error("status capability bits read wrong");

    a_irq_level: assert property ( // see R8
        (parity_error_seen_reg && irq_mask_reg[bridge_regs_pkg::PERR_BIT]) |=> irq_reg)
        else $error("unmasked parity flag did not raise the interrupt");

endmodule : bridge_io_window_secondary_status

// *** src/tenure_timer.sv ***
`timescale 1ns/1ps

module tenure_timer (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [4:0] limit_value,
    input  wire logic       frame_active,
    input  wire logic       grant_held,
    output logic            stop
);

    logic [7:0] count_reg;
    logic       frame_d_reg;
    logic       stop_reg;
    logic       expired;

    assign stop = stop_reg;

    // Track the start of each tenure so the count reloads once per frame.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_d_reg <= 1'b0;
        end else begin
            frame_d_reg <= frame_active;
        end
    end

    // Count down the programmed tenure; a zero value never loads a limit.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= 8'h00;
        end else if (frame_active && !frame_d_reg) begin
            count_reg <= 8'({3'h0, limit_value} << bridge_regs_pkg::TENURE_SHIFT);
        end else if (frame_active && count_reg != 8'h00) begin
            count_reg <= count_reg - 8'h01;
        end
    end

    // Expiry alone does not end a tenure; the grant must also be gone.
    assign expired = frame_active && frame_d_reg && (count_reg == 8'h00)
                     && (limit_value != 5'h00);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stop_reg <= 1'b0;
        end else begin
            stop_reg <= expired && !grant_held;
        end
    end

endmodule : tenure_timer
